// ==== shared/rpsc_pkg.sv ====
/*
 Package for the reset and power state control block: register offsets,
 field positions, reset values, state encodings and sequencing counts.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package rpsc_pkg;
	// Register offsets on the control port
	localparam logic [7:0] RESET_CONTROL_OFS       = 8'h01;
	localparam logic [7:0] POWER_STATE_REQUEST_OFS = 8'h02;
	localparam logic [7:0] CHANNEL_MUTE_REQUEST_OFS = 8'h03;
	// Field positions
	localparam int MODULE_RESET_BIT       = 4;
	localparam int REGISTER_RESET_BIT     = 0;
	localparam int PROCESSOR_RESET_BIT    = 7;
	localparam int STANDBY_REQUEST_BIT    = 4;
	localparam int POWERDOWN_REQUEST_BIT  = 0;
	localparam int LEFT_MUTE_REQUEST_BIT  = 4;
	localparam int RIGHT_MUTE_REQUEST_BIT = 0;
	// Values after reset
	localparam logic [7:0] RESET_CONTROL_RST        = 8'h00;
	localparam logic [7:0] POWER_STATE_REQUEST_RST  = 8'h80;
	localparam logic [7:0] CHANNEL_MUTE_REQUEST_RST = 8'h00;
	// Write masks: register 3 bits 7-5 are read only
	localparam logic [7:0] CHANNEL_MUTE_WMASK = 8'h1f;
	// Sequencing counts in clock cycles
	localparam int RESET_PULSE_CYCLES = 4;
	// Power states, Gray along run to standby to powerdown
	typedef enum logic [1:0] {
		RPSC_RUN       = 2'b00,
		RPSC_STANDBY   = 2'b01,
		RPSC_POWERDOWN = 2'b11
	} rpsc_state_e;
endpackage
`default_nettype wire

// ==== src/rpsc_pulse.sv ====
/*
 Reset pulse stretcher: a start pulse yields a busy level held for a fixed
 number of cycles. Assumes start comes from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rpsc_pulse #(
	parameter int CYCLES = rpsc_pkg::RESET_PULSE_CYCLES
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Control
	input  wire logic start,
	output var  logic busy
);
	logic [7:0] cnt_reg;

	// Count down while busy; a new start restarts the count
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg <= 8'h00;
		end else if (start) begin
			cnt_reg <= 8'(CYCLES);
		end else if (cnt_reg != 8'h00) begin
			cnt_reg <= cnt_reg - 8'h01;
		end
	end

	assign busy = (cnt_reg != 8'h00);
endmodule
`default_nettype wire

// ==== src/rpsc_top.sv ====
/*
 Reset and power state control registers with their sequencing.
 Assumes a decoded control-port write/read strobe on clk from the serial
 port logic, and a clock-error level from a foreign domain.
*/
`timescale 1ns/1ps
`default_nettype none
module rpsc_top (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Control port access
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	output logic      [7:0] rdata,
	output logic            rvalid,
	// Clock error detector level, asynchronous
	input  wire logic       clock_error,
	// Resets to processing modules
	output logic            filter_reset,
	output logic            converter_reset,
	output logic            processor_reset,
	output logic            coef_clear,
	output logic            mode_reg_reset,
	output logic            exec_from_rom,
	// Power controls
	output logic            analog_power_en,
	output logic            charge_pump_en,
	output logic            digital_supply_en,
	output logic            in_standby,
	output logic            in_powerdown,
	// Mute requests toward the ramp logic
	output logic            left_mute_request,
	output logic            right_mute_request
);
	logic [7:0] mute_reg;
	logic       processor_reset_reg, standby_request_reg;
	logic       powerdown_request_reg;
	logic       module_reset_reg, register_reset_reg;
	logic       err_s1_reg, err_s2_reg;
	logic       mod_start, reg_start, mod_busy, reg_busy;
	logic       wr_rst, wr_pwr, wr_mute;
	rpsc_pkg::rpsc_state_e state_reg, state_next;

	assign wr_rst  = wr_en && addr == rpsc_pkg::RESET_CONTROL_OFS;
	assign wr_pwr  = wr_en && addr == rpsc_pkg::POWER_STATE_REQUEST_OFS;
	assign wr_mute = wr_en && addr == rpsc_pkg::CHANNEL_MUTE_REQUEST_OFS;

	// Clock error comes from another domain, so synchronise it
	always_ff @(posedge clk) begin
		if (rst) begin
			err_s1_reg <= 1'b0;
			err_s2_reg <= 1'b0;
		end else begin
			err_s1_reg <= clock_error;
			err_s2_reg <= err_s1_reg;
		end
	end

	// standby only gate
	// Module reset is dropped unless the device already sits in standby
	assign mod_start = wr_rst && wdata[rpsc_pkg::MODULE_RESET_BIT]
		&& state_reg == rpsc_pkg::RPSC_STANDBY && !module_reset_reg;
	// host restricts use
	// Register reset is taken in any state; the host keeps it to standby
	assign reg_start = wr_rst && wdata[rpsc_pkg::REGISTER_RESET_BIT]
		&& !register_reset_reg;

	rpsc_pulse #(.CYCLES(rpsc_pkg::RESET_PULSE_CYCLES)) u_mod_pulse (
		.clk   (clk),
		.rst   (rst),
		.start (mod_start),
		.busy  (mod_busy)
	);

	rpsc_pulse #(.CYCLES(rpsc_pkg::RESET_PULSE_CYCLES)) u_reg_pulse (
		.clk   (clk),
		.rst   (rst),
		.start (reg_start),
		.busy  (reg_busy)
	);

	// self clearing bits
	// The bits stay set while the action runs, then drop to zero
	always_ff @(posedge clk) begin
		if (rst) begin
			module_reset_reg   <= 1'b0;
			register_reset_reg <= 1'b0;
		end else begin
			module_reset_reg   <= mod_start || (module_reset_reg && mod_busy);
			register_reset_reg <= reg_start
				|| (register_reset_reg && reg_busy);
		end
	end

	// processor reset default
	// Register reset returns the mode bits to their values after reset
	always_ff @(posedge clk) begin
		if (rst || register_reset_reg) begin
			processor_reset_reg   <= rpsc_pkg::POWER_STATE_REQUEST_RST[7];
			standby_request_reg   <= 1'b0;
			powerdown_request_reg <= 1'b0;
			mute_reg              <= rpsc_pkg::CHANNEL_MUTE_REQUEST_RST;
		end else begin
			if (wr_pwr) begin
				processor_reset_reg   <=
					wdata[rpsc_pkg::PROCESSOR_RESET_BIT];
				standby_request_reg   <=
					wdata[rpsc_pkg::STANDBY_REQUEST_BIT];
				powerdown_request_reg <=
					wdata[rpsc_pkg::POWERDOWN_REQUEST_BIT];
			end
			if (wr_mute) begin
				mute_reg <= wdata & rpsc_pkg::CHANNEL_MUTE_WMASK;
			end
		end
	end

	always_comb begin
		if (powerdown_request_reg) begin
			state_next = rpsc_pkg::RPSC_POWERDOWN;
		end else if (standby_request_reg || err_s2_reg) begin
			state_next = rpsc_pkg::RPSC_STANDBY;
		end else begin
			state_next = rpsc_pkg::RPSC_RUN;
		end
	end

	// Power state register
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= rpsc_pkg::RPSC_RUN;
		end else begin
			case (state_reg)
				rpsc_pkg::RPSC_RUN:       state_reg <= state_next;
				rpsc_pkg::RPSC_STANDBY:   state_reg <= state_next;
				rpsc_pkg::RPSC_POWERDOWN: state_reg <= state_next;
				default:                  state_reg <= rpsc_pkg::RPSC_RUN;
			endcase
		end
	end

	// module resets
	// Outputs registered from the state, reset and mute bits
	always_ff @(posedge clk) begin
		if (rst) begin
			filter_reset       <= 1'b0;
			converter_reset    <= 1'b0;
			processor_reset    <= 1'b1;
			coef_clear         <= 1'b0;
			mode_reg_reset     <= 1'b0;
			exec_from_rom      <= 1'b1;
			analog_power_en    <= 1'b1;
			charge_pump_en     <= 1'b1;
			digital_supply_en  <= 1'b1;
			in_standby         <= 1'b0;
			in_powerdown       <= 1'b0;
			left_mute_request  <= 1'b0;
			right_mute_request <= 1'b0;
		end else begin
			filter_reset      <= module_reset_reg;
			converter_reset   <= module_reset_reg;
			processor_reset   <= module_reset_reg || processor_reset_reg;
			coef_clear        <= module_reset_reg;
			mode_reg_reset    <= register_reset_reg;
			// ROM stays selected until software lifts the processor reset
			exec_from_rom     <= register_reset_reg
				|| (exec_from_rom && processor_reset_reg);
			analog_power_en   <= state_reg == rpsc_pkg::RPSC_RUN;
			charge_pump_en    <= state_reg != rpsc_pkg::RPSC_POWERDOWN;
			digital_supply_en <= state_reg != rpsc_pkg::RPSC_POWERDOWN;
			in_standby        <= state_reg == rpsc_pkg::RPSC_STANDBY;
			in_powerdown      <= state_reg == rpsc_pkg::RPSC_POWERDOWN;
			left_mute_request <= mute_reg[rpsc_pkg::LEFT_MUTE_REQUEST_BIT];
			right_mute_request <=
				mute_reg[rpsc_pkg::RIGHT_MUTE_REQUEST_BIT];
		end
	end

	// Read path, one cycle after rd_en; unmapped offsets read zero
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata  <= 8'h00;
			rvalid <= 1'b0;
		end else begin
			rvalid <= rd_en;
			case (addr)
				rpsc_pkg::RESET_CONTROL_OFS:
					rdata <= {3'h0, module_reset_reg, 3'h0, register_reset_reg};
				rpsc_pkg::POWER_STATE_REQUEST_OFS:
					rdata <= {processor_reset_reg, 2'h0, standby_request_reg,
						3'h0, powerdown_request_reg};
				rpsc_pkg::CHANNEL_MUTE_REQUEST_OFS:
					rdata <= mute_reg;
				default:
					rdata <= 8'h00;
			endcase
		end
	end

	// Sequence used by the module reset pulse and self-clear checks below
	sequence seq_mod_req;
		wr_rst && wdata[4] && state_reg == rpsc_pkg::RPSC_STANDBY
			&& !module_reset_reg;
	endsequence

	AST_MOD_RESET_PULSE: assert property (@(posedge clk) disable iff (rst)
		seq_mod_req |-> ##2 filter_reset && coef_clear && processor_reset)
		else $error("module reset did not reach the modules");
	AST_MOD_RESET_GATED: assert property (@(posedge clk) disable iff (rst)
		(wr_rst && wdata[4] && state_reg == rpsc_pkg::RPSC_RUN
			&& !module_reset_reg) |=> !module_reset_reg)
		else $error("module reset accepted outside standby");
	AST_MOD_SELF_CLEAR: assert property (@(posedge clk) disable iff (rst)
		seq_mod_req |-> ##[1:8] !module_reset_reg)
		else $error("module reset bit did not clear");
	AST_REG_RESTORE: assert property (@(posedge clk) disable iff (rst)
		register_reset_reg |=> processor_reset_reg && mute_reg == 8'h00)
		else $error("register reset did not restore mode bits");
	AST_PROC_WRITE_ZERO: assert property (@(posedge clk) disable iff (rst)
		(wr_pwr && !wdata[7] && !register_reset_reg) |-> ##2 !processor_reset
			|| $past(module_reset_reg))
		else $error("processor did not leave reset");
	AST_STANDBY_ENTRY: assert property (@(posedge clk) disable iff (rst)
		(standby_request_reg && !powerdown_request_reg) |=> ##1 in_standby)
		else $error("standby request not honoured");
	AST_STANDBY_SUPPLY: assert property (@(posedge clk) disable iff (rst)
		in_standby |-> charge_pump_en && digital_supply_en && !analog_power_en)
		else $error("standby supplies wrong");
	AST_PD_SUPPLY: assert property (@(posedge clk) disable iff (rst)
		in_powerdown |-> !charge_pump_en && !analog_power_en)
		else $error("powerdown left the charge pump on");
	AST_PD_PRIORITY: assert property (@(posedge clk) disable iff (rst)
		(powerdown_request_reg && standby_request_reg) |=> ##1 in_powerdown
			&& !charge_pump_en)
		else $error("powerdown did not take priority");
	AST_MUTE_FOLLOW: assert property (@(posedge clk) disable iff (rst)
		(wr_mute && !register_reset_reg) |-> ##2 left_mute_request == $past(
			wdata[4], 2) && right_mute_request == $past(wdata[0], 2))
		else $error("mute request did not follow write");
endmodule
`default_nettype wire

// ==== tb/rpsc_host.sv ====
/*
 Host controller model for the control port: byte writes and reads.
 Assumes the block samples its strobes on the rising edge of clk.
*/
`timescale 1ns/1ps
`default_nettype none
module rpsc_host (
	// Clock
	input  wire logic       clk,
	// Control port
	output logic            wr_en,
	output logic            rd_en,
	output logic      [7:0] addr,
	output logic      [7:0] wdata
);
	logic [7:0] exp_q[$]; // Expected read bytes, oldest first

	// Strobes idle from time zero
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
	end

	// register reset only in standby
	// processor reset cleared only on settled clocks
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
		// Released bus shows inverted bytes so stale data never looks valid
		addr = ~a;
		wdata = ~d;
	endtask

	// Read, noting the expected byte before the strobe goes out
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		exp_q.push_back(e);
		addr = a;
		rd_en = 1'b1;
		@(negedge clk);
		rd_en = 1'b0;
		addr = ~a;
	endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
/*
 Self-checking bench for the reset and power state control block.
 Assumes the host model drives the control port on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic       clk, rst, wr_en, rd_en, rvalid, clock_error;
	logic [7:0] addr, wdata, rdata, seed;
	logic       filt_r, conv_r, proc_r, coef_c, mode_r, rom_x;
	logic       ana_en, pump_en, dig_en, stby, pdn, mute_l, mute_r;
	int         error_cnt, checks, n, i;

	rpsc_top rpsc_top_i (.clk(clk), .rst(rst), .wr_en(wr_en),
		.rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata),
		.rvalid(rvalid), .clock_error(clock_error),
		.filter_reset(filt_r), .converter_reset(conv_r),
		.processor_reset(proc_r), .coef_clear(coef_c),
		.mode_reg_reset(mode_r), .exec_from_rom(rom_x),
		.analog_power_en(ana_en), .charge_pump_en(pump_en),
		.digital_supply_en(dig_en), .in_standby(stby),
		.in_powerdown(pdn), .left_mute_request(mute_l),
		.right_mute_request(mute_r));
	rpsc_host rpsc_host_i (.clk(clk), .wr_en(wr_en), .rd_en(rd_en),
		.addr(addr), .wdata(wdata));

	// Clock at 40 MHz
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic fail(input string m);
		error_cnt++;
		$display("CHECK FAILED t=%0t %s", $time, m);
	endtask
	task automatic cmp_rd(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) fail($sformatf("read %h exp %h", g, e));
	endtask
	task automatic cmp_lvl(input logic g, input logic e, input string m);
		checks++;
		if (g !== e) fail(m);
	endtask
	task automatic conclude();
		if (error_cnt == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// A wait that ran out of cycles ends the run
	task automatic tmo(input int c);
		if (c >= 12) begin
			fail("wait ran out");
			conclude();
		end
	endtask

	// Each read answer is matched against the oldest note
	always @(posedge clk) begin
		if (rvalid === 1'b1) begin
			if (rpsc_host_i.exp_q.size() == 0) fail("unexpected read");
			else cmp_rd(rdata, rpsc_host_i.exp_q.pop_front());
		end
	end

	initial begin
		error_cnt = 0;
		checks = 0;
		seed = 8'h0d;
		rst = 1'b1;
		clock_error = 1'b0;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		// Values after reset, unmapped offset reads zero
		rpsc_host_i.rd(8'h01, 8'h00);
		rpsc_host_i.rd(8'h02, 8'h80);
		rpsc_host_i.rd(8'h03, 8'h00);
		rpsc_host_i.rd(8'h04, 8'h00);
		cmp_lvl(proc_r, 1'b1, "processor reset");
		cmp_lvl(rom_x, 1'b1, "rom source");
		// Pseudo-random mute bytes; the top three bits are read only
		for (i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			rpsc_host_i.wr(8'h03, seed);
			rpsc_host_i.rd(8'h03, seed & 8'h1f);
			cmp_lvl(mute_l, seed[4], "left mute");
			cmp_lvl(mute_r, seed[0], "right mute");
		end
		// Processor start, then module reset refused while running
		rpsc_host_i.wr(8'h02, 8'h00);
		repeat (4) @(negedge clk);
		cmp_lvl(proc_r, 1'b0, "processor start");
		cmp_lvl(rom_x, 1'b0, "rom released on start");
		cmp_lvl(ana_en, 1'b1, "run power");
		rpsc_host_i.wr(8'h01, 8'h10);
		repeat (3) @(negedge clk);
		cmp_lvl(filt_r, 1'b0, "module reset in run");
		rpsc_host_i.rd(8'h01, 8'h00);
		// Standby request, then module reset accepted
		rpsc_host_i.wr(8'h02, 8'h10);
		repeat (4) @(negedge clk);
		cmp_lvl(stby, 1'b1, "standby");
		cmp_lvl(ana_en, 1'b0, "standby analog");
		cmp_lvl(pump_en & dig_en, 1'b1, "standby supplies");
		rpsc_host_i.wr(8'h01, 8'h10);
		for (n = 0; n < 12 && filt_r !== 1'b1; n++) @(negedge clk);
		tmo(n);
		cmp_lvl(conv_r & coef_c & proc_r, 1'b1, "module resets");
		for (n = 0; n < 12 && filt_r !== 1'b0; n++) @(negedge clk);
		tmo(n);
		rpsc_host_i.rd(8'h01, 8'h00);
		cmp_lvl(proc_r, 1'b0, "processor released");
		// Both requests: powerdown wins
		rpsc_host_i.wr(8'h02, 8'h11);
		repeat (4) @(negedge clk);
		cmp_lvl(pdn, 1'b1, "powerdown");
		cmp_lvl(pump_en | dig_en, 1'b0, "pump off");
		// Clock error forces standby while present
		rpsc_host_i.wr(8'h02, 8'h00);
		repeat (4) @(negedge clk);
		cmp_lvl(stby | pdn, 1'b0, "back to run");
		clock_error = 1'b1;
		for (n = 0; n < 12 && stby !== 1'b1; n++) @(negedge clk);
		tmo(n);
		clock_error = 1'b0;
		for (n = 0; n < 12 && stby !== 1'b0; n++) @(negedge clk);
		tmo(n);
		// Register reset, issued in standby
		rpsc_host_i.wr(8'h02, 8'h10);
		repeat (4) @(negedge clk);
		rpsc_host_i.wr(8'h01, 8'h01);
		for (n = 0; n < 12 && mode_r !== 1'b1; n++) @(negedge clk);
		tmo(n);
		for (n = 0; n < 12 && mode_r !== 1'b0; n++) @(negedge clk);
		tmo(n);
		rpsc_host_i.rd(8'h01, 8'h00);
		rpsc_host_i.rd(8'h02, 8'h80);
		rpsc_host_i.rd(8'h03, 8'h00);
		cmp_lvl(rom_x, 1'b1, "rom after register reset");
		repeat (4) @(negedge clk);
		if (rpsc_host_i.exp_q.size() != 0) fail("reads unanswered");
		conclude();
	end
endmodule
`default_nettype wire
